// >>> include/aim_regs.vh
// Register map, field layout and protocol constants of the access rule entry matcher.
//
// Overview of operation
// RL1 - Destination network mode compares frame destination IPv4 under address and mask.
// RL2 - A destination IPv4 address is held for host and network modes.
// RL3 - The destination mask is applied only in network mode.
// RL4 - Opcode class any ignores the opcode field.
// RL5 - Class ARP matches ARP opcodes only; class RARP matches RARP opcodes only.
// RL6 - Class other matches opcodes that are neither ARP nor RARP codes.
// RL7 - Request matches ARP or RARP request opcodes; any disables the check.
// RL8 - Reply matches ARP or RARP reply opcodes only.
// RL9 - Sender host mode needs sender protocol address equal to configured; any disables.
// RL10 - Sender network mode compares sender address under the sender mask.
// RL11 - The sender mask is applied only in sender network mode.
// RL12 - Target host mode needs target protocol address equal to configured; any disables.
// RL13 - Target network mode compares target address using masked bits only.
// RL14 - Sender hardware setting 1 matches ARP frames whose SHA equals source MAC.
// RL15 - Target hardware setting 0 matches RARP frames whose THA differs from source MAC.
// RL16 - Target hardware setting 1 matches RARP frames whose THA equals source MAC.
// RL17 - Length setting 1 needs HLN 0x06 and PLN 0x04; setting 0 rejects those.
// RL18 - Hardware space setting 0 rejects frames whose HRD is Ethernet 1.
// RL19 - Consistency or length setting any ignores the corresponding header field.
// RL20 - Sender hardware setting 0 matches ARP frames whose SHA differs from source MAC.
// RL21 - A hit needs every active criterion satisfied together.
// RL22 - Hardware space setting 1 matches only frames whose HRD is Ethernet 1.
// RL23 - Network compare: frame address and mask equals configured address and mask.
`ifndef AIM_REGS_VH
`define AIM_REGS_VH

// ==========================================================================
// Register byte offsets.
`define AIM_OFS_CTRL 8'h00
`define AIM_OFS_DIP_ADDR 8'h04
`define AIM_OFS_DIP_MASK 8'h08
`define AIM_OFS_SIP_ADDR 8'h0c
`define AIM_OFS_SIP_MASK 8'h10
`define AIM_OFS_TIP_ADDR 8'h14
`define AIM_OFS_TIP_MASK 8'h18
`define AIM_OFS_STATUS 8'h1c
`define AIM_OFS_HIT_CNT 8'h20
`define AIM_OFS_FRM_CNT 8'h24

// ==========================================================================
// Control register fields (low bit positions, two bits wide except the one-bit enable).
`define AIM_CTRL_DIP 0
`define AIM_CTRL_OPC 2
`define AIM_CTRL_RR 4
`define AIM_CTRL_SIP 6
`define AIM_CTRL_TIP 8
`define AIM_CTRL_SHA 10
`define AIM_CTRL_THA 12
`define AIM_CTRL_LEN 14
`define AIM_CTRL_HRD 16
`define AIM_CTRL_EN 18
`define AIM_CTRL_MASK 32'h0007ffff

// ==========================================================================
// Reset values.
`define AIM_RST_CTRL 32'h00000000
`define AIM_RST_WORD 32'h00000000

// ==========================================================================
// Criterion encodings.
`define AIM_IP_ANY 2'h0
`define AIM_IP_HOST 2'h1
`define AIM_IP_NET 2'h2
`define AIM_OPC_ANY 2'h0
`define AIM_OPC_ARP 2'h1
`define AIM_OPC_RARP 2'h2
`define AIM_OPC_OTHER 2'h3
`define AIM_RR_ANY 2'h0
`define AIM_RR_REQ 2'h1
`define AIM_RR_REP 2'h2

// ==========================================================================
// Header field values.
`define AIM_OP_ARP_REQ 16'h0001
`define AIM_OP_ARP_REP 16'h0002
`define AIM_OP_RARP_REQ 16'h0003
`define AIM_OP_RARP_REP 16'h0004
`define AIM_HLN_ETH 8'h06
`define AIM_PLN_IPV4 8'h04
`define AIM_HRD_ETH 16'h0001

`endif

// >>> core/aim_ip_cmp.v
// IPv4 host or network compare for one address criterion.
`timescale 1ns/10ps
`include "aim_regs.vh"
module aim_ip_cmp (
   // Criterion setting.
   input wire [1:0] mode,
   input wire [31:0] cfg_addr,
   input wire [31:0] cfg_mask,
   // Frame field.
   input wire [31:0] frm_addr,
   // Result.
   output reg ok
);

   // Host compares every bit, network only the masked bits, other modes pass.
   always @* begin
      if (mode == `AIM_IP_HOST) begin
         ok = (frm_addr == cfg_addr);
      end else if (mode == `AIM_IP_NET) begin
         ok = ((frm_addr & cfg_mask) == (cfg_addr & cfg_mask)); // RL23
      end else begin
         ok = 1'b1;
      end
   end

endmodule

// >>> core/aim_op_class.v
// Classifies an ARP or RARP opcode into class and request or reply.
`timescale 1ns/10ps
`include "aim_regs.vh"
module aim_op_class (
   // Opcode field of the frame.
   input wire [15:0] opcode,
   // Class outputs.
   output wire is_arp,
   output wire is_rarp,
   output wire is_req,
   output wire is_rep
);

   // Request and reply codes of both protocols are recognised.
   assign is_arp = (opcode == `AIM_OP_ARP_REQ) || (opcode == `AIM_OP_ARP_REP);
   assign is_rarp = (opcode == `AIM_OP_RARP_REQ) || (opcode == `AIM_OP_RARP_REP);
   assign is_req = (opcode == `AIM_OP_ARP_REQ) || (opcode == `AIM_OP_RARP_REQ);
   assign is_rep = (opcode == `AIM_OP_ARP_REP) || (opcode == `AIM_OP_RARP_REP);

endmodule

// >>> core/aim_core.v
// Access rule entry matcher with its Avalon-MM register slave.
`timescale 1ns/10ps
`include "aim_regs.vh"
module aim_core (
   // Clock and reset.
   input wire SYS_CLK,
   input wire RESET,
   // Avalon-MM slave.
   input wire [7:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output wire [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   // Parsed frame fields from the frame parser.
   input wire FRM_VALID,
   input wire FRM_IS_ARP,
   input wire [31:0] FRM_DEST_IP,
   input wire [47:0] FRM_SOURCE_MAC,
   input wire [15:0] FRM_OPCODE,
   input wire [15:0] FRM_HRD,
   input wire [7:0] FRM_HLN,
   input wire [7:0] FRM_PLN,
   input wire [47:0] FRM_SHA,
   input wire [47:0] FRM_THA,
   input wire [31:0] FRM_SPA,
   input wire [31:0] FRM_TPA,
   // Match result.
   output wire MATCH_VALID,
   output wire MATCH_HIT
);

   // ========================================================================
   // Functions.

   // Merges write data into a word under the byte enables.
   function [31:0] be_merge;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0] be;
      integer i;
      begin
         be_merge = old_word;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               be_merge[i*8 +: 8] = new_word[i*8 +: 8];
            end
         end
      end
   endfunction

   // Three-way setting: high bit clear is any, otherwise the low bit is the wanted truth.
   function tri_ok;
      input [1:0] sel;
      input cond;
      begin
         if (!sel[1]) begin
            tri_ok = 1'b1;
         end else begin
            tri_ok = (cond == sel[0]);
         end
      end
   endfunction

   // Increments a counter, but a coincident clear still counts the new event.
   function [31:0] cnt_next;
      input [31:0] cnt;
      input inc;
      input clr;
      begin
         if (clr) begin
            cnt_next = inc ? 32'h00000001 : 32'h00000000;
         end else if (inc) begin
            cnt_next = cnt + 32'h00000001;
         end else begin
            cnt_next = cnt;
         end
      end
   endfunction

   // ========================================================================
   // Configuration and status registers.
   reg [31:0] ctrl_r;
   reg [31:0] dip_addr_r;
   reg [31:0] dip_mask_r;
   reg [31:0] sip_addr_r;
   reg [31:0] sip_mask_r;
   reg [31:0] tip_addr_r;
   reg [31:0] tip_mask_r;
   reg [31:0] hit_cnt_r;
   reg [31:0] frm_cnt_r;
   reg [9:0] fail_r;
   reg last_hit_r;
   reg seen_r;

   // Bus handshake registers.
   reg wait_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;

   // Result registers.
   reg match_valid_r;
   reg match_hit_r;

   // ========================================================================
   // Control field decode.
   wire [1:0] dip_mode = ctrl_r[`AIM_CTRL_DIP +: 2];
   wire [1:0] opc_sel = ctrl_r[`AIM_CTRL_OPC +: 2];
   wire [1:0] rr_sel = ctrl_r[`AIM_CTRL_RR +: 2];
   wire [1:0] sip_mode = ctrl_r[`AIM_CTRL_SIP +: 2];
   wire [1:0] tip_mode = ctrl_r[`AIM_CTRL_TIP +: 2];
   wire [1:0] sha_sel = ctrl_r[`AIM_CTRL_SHA +: 2];
   wire [1:0] tha_sel = ctrl_r[`AIM_CTRL_THA +: 2];
   wire [1:0] len_sel = ctrl_r[`AIM_CTRL_LEN +: 2];
   wire [1:0] hrd_sel = ctrl_r[`AIM_CTRL_HRD +: 2];
   wire entry_en = ctrl_r[`AIM_CTRL_EN];

   // ========================================================================
   // Address compares and opcode classification.
   wire dip_ok;
   wire sip_ip_ok;
   wire tip_ip_ok;
   wire op_arp;
   wire op_rarp;
   wire op_req;
   wire op_rep;

   // Destination address compare, mask used in network mode only.
   aim_ip_cmp u_dip (
      .mode(dip_mode),
      .cfg_addr(dip_addr_r),
      .cfg_mask(dip_mask_r),
      .frm_addr(FRM_DEST_IP),
      .ok(dip_ok)
   ); // RL1 RL2 RL3

   // Sender protocol address compare.
   aim_ip_cmp u_sip (
      .mode(sip_mode),
      .cfg_addr(sip_addr_r),
      .cfg_mask(sip_mask_r),
      .frm_addr(FRM_SPA),
      .ok(sip_ip_ok)
   ); // RL9 RL10 RL11

   // Target protocol address compare.
   aim_ip_cmp u_tip (
      .mode(tip_mode),
      .cfg_addr(tip_addr_r),
      .cfg_mask(tip_mask_r),
      .frm_addr(FRM_TPA),
      .ok(tip_ip_ok)
   ); // RL12 RL13

   // Opcode class of the frame.
   aim_op_class u_op (
      .opcode(FRM_OPCODE),
      .is_arp(op_arp),
      .is_rarp(op_rarp),
      .is_req(op_req),
      .is_rep(op_rep)
   );

   // ========================================================================
   // Criterion evaluation.
   reg opc_ok;
   reg rr_ok;
   wire sip_active = (sip_mode == `AIM_IP_HOST) || (sip_mode == `AIM_IP_NET);
   wire tip_active = (tip_mode == `AIM_IP_HOST) || (tip_mode == `AIM_IP_NET);
   wire sip_ok = sip_active ? (FRM_IS_ARP && sip_ip_ok) : 1'b1;
   wire tip_ok = tip_active ? (FRM_IS_ARP && tip_ip_ok) : 1'b1;
   wire sha_same = (FRM_SHA == FRM_SOURCE_MAC);
   wire tha_same = (FRM_THA == FRM_SOURCE_MAC);
   wire len_std = (FRM_HLN == `AIM_HLN_ETH) && (FRM_PLN == `AIM_PLN_IPV4);
   wire hrd_eth = (FRM_HRD == `AIM_HRD_ETH);

   // Opcode class and request or reply checks; a set check needs an ARP/RARP frame.
   always @* begin
      if (opc_sel == `AIM_OPC_ANY) begin
         opc_ok = 1'b1; // RL4
      end else if (opc_sel == `AIM_OPC_ARP) begin
         opc_ok = FRM_IS_ARP && op_arp; // RL5
      end else if (opc_sel == `AIM_OPC_RARP) begin
         opc_ok = FRM_IS_ARP && op_rarp; // RL5
      end else begin
         opc_ok = FRM_IS_ARP && !op_arp && !op_rarp; // RL6
      end
      if (rr_sel == `AIM_RR_REQ) begin
         rr_ok = FRM_IS_ARP && op_req; // RL7
      end else if (rr_sel == `AIM_RR_REP) begin
         rr_ok = FRM_IS_ARP && op_rep; // RL8
      end else begin
         rr_ok = 1'b1; // RL7
      end
   end

   // Sender hardware consistency applies to ARP frames, target to RARP frames.
   wire sha_ok = !sha_sel[1] || (FRM_IS_ARP && op_arp && tri_ok(sha_sel, sha_same)); // RL14 RL20 RL19
   wire tha_ok = !tha_sel[1] || (FRM_IS_ARP && op_rarp && tri_ok(tha_sel, tha_same)); // RL15 RL16 RL19
   wire len_ok = !len_sel[1] || (FRM_IS_ARP && tri_ok(len_sel, len_std)); // RL17 RL19
   wire hrd_ok = !hrd_sel[1] || (FRM_IS_ARP && tri_ok(hrd_sel, hrd_eth)); // RL18 RL22

   // Failure flags of every criterion, bit order as in the status register.
   wire [9:0] fail_now = {~entry_en, ~hrd_ok, ~len_ok, ~tha_ok, ~sha_ok,
                          ~tip_ok, ~sip_ok, ~rr_ok, ~opc_ok, ~dip_ok};

   // The entry hits only when nothing failed.
   wire hit_now = (fail_now == 10'h000); // RL21

   // ========================================================================
   // Result pipeline: one registered result per presented frame.
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         match_valid_r <= 1'b0;
         match_hit_r <= 1'b0;
         last_hit_r <= 1'b0;
         fail_r <= 10'h000;
         seen_r <= 1'b0;
      end else begin
         match_valid_r <= FRM_VALID;
         match_hit_r <= FRM_VALID && hit_now; // RL21
         if (FRM_VALID) begin
            last_hit_r <= hit_now;
            fail_r <= fail_now;
            seen_r <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Avalon-MM access decode.
   wire bus_req = AVS_READ || AVS_WRITE;
   wire bus_take = bus_req && !wait_r;
   wire wr_take = AVS_WRITE && !wait_r;
   wire wr_ctrl = wr_take && (AVS_ADDRESS == `AIM_OFS_CTRL);
   wire wr_dip_a = wr_take && (AVS_ADDRESS == `AIM_OFS_DIP_ADDR);
   wire wr_dip_m = wr_take && (AVS_ADDRESS == `AIM_OFS_DIP_MASK);
   wire wr_sip_a = wr_take && (AVS_ADDRESS == `AIM_OFS_SIP_ADDR);
   wire wr_sip_m = wr_take && (AVS_ADDRESS == `AIM_OFS_SIP_MASK);
   wire wr_tip_a = wr_take && (AVS_ADDRESS == `AIM_OFS_TIP_ADDR);
   wire wr_tip_m = wr_take && (AVS_ADDRESS == `AIM_OFS_TIP_MASK);
   wire clr_hit = wr_take && (AVS_ADDRESS == `AIM_OFS_HIT_CNT);
   wire clr_frm = wr_take && (AVS_ADDRESS == `AIM_OFS_FRM_CNT);

   // Read data multiplexer; unmapped addresses read as zero.
   always @* begin
      if (AVS_ADDRESS == `AIM_OFS_CTRL) begin
         rdata_nxt = ctrl_r;
      end else if (AVS_ADDRESS == `AIM_OFS_DIP_ADDR) begin
         rdata_nxt = dip_addr_r;
      end else if (AVS_ADDRESS == `AIM_OFS_DIP_MASK) begin
         rdata_nxt = dip_mask_r;
      end else if (AVS_ADDRESS == `AIM_OFS_SIP_ADDR) begin
         rdata_nxt = sip_addr_r;
      end else if (AVS_ADDRESS == `AIM_OFS_SIP_MASK) begin
         rdata_nxt = sip_mask_r;
      end else if (AVS_ADDRESS == `AIM_OFS_TIP_ADDR) begin
         rdata_nxt = tip_addr_r;
      end else if (AVS_ADDRESS == `AIM_OFS_TIP_MASK) begin
         rdata_nxt = tip_mask_r;
      end else if (AVS_ADDRESS == `AIM_OFS_STATUS) begin
         rdata_nxt = {20'h00000, fail_r, seen_r, last_hit_r};
      end else if (AVS_ADDRESS == `AIM_OFS_HIT_CNT) begin
         rdata_nxt = hit_cnt_r;
      end else if (AVS_ADDRESS == `AIM_OFS_FRM_CNT) begin
         rdata_nxt = frm_cnt_r;
      end else begin
         rdata_nxt = 32'h00000000;
      end
   end

   // Waitrequest drops for one cycle, one cycle after a request appears.
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         if (bus_req && wait_r) begin
            wait_r <= 1'b0;
            rdata_r <= AVS_READ ? rdata_nxt : 32'h00000000;
         end else begin
            wait_r <= 1'b1;
         end
      end
   end

   // ========================================================================
   // Configuration writes, taken at the edge where waitrequest is low.
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         ctrl_r <= `AIM_RST_CTRL;
         dip_addr_r <= `AIM_RST_WORD;
         dip_mask_r <= `AIM_RST_WORD;
         sip_addr_r <= `AIM_RST_WORD;
         sip_mask_r <= `AIM_RST_WORD;
         tip_addr_r <= `AIM_RST_WORD;
         tip_mask_r <= `AIM_RST_WORD;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= be_merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE) & `AIM_CTRL_MASK;
         end
         if (wr_dip_a) begin
            dip_addr_r <= be_merge(dip_addr_r, AVS_WRITEDATA, AVS_BYTEENABLE); // RL2
         end
         if (wr_dip_m) begin
            dip_mask_r <= be_merge(dip_mask_r, AVS_WRITEDATA, AVS_BYTEENABLE); // RL3
         end
         if (wr_sip_a) begin
            sip_addr_r <= be_merge(sip_addr_r, AVS_WRITEDATA, AVS_BYTEENABLE);
         end
         if (wr_sip_m) begin
            sip_mask_r <= be_merge(sip_mask_r, AVS_WRITEDATA, AVS_BYTEENABLE); // RL11
         end
         if (wr_tip_a) begin
            tip_addr_r <= be_merge(tip_addr_r, AVS_WRITEDATA, AVS_BYTEENABLE);
         end
         if (wr_tip_m) begin
            tip_mask_r <= be_merge(tip_mask_r, AVS_WRITEDATA, AVS_BYTEENABLE);
         end
      end
   end

   // Hit and frame counters; a write clears them but a same-cycle event survives.
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         hit_cnt_r <= 32'h00000000;
         frm_cnt_r <= 32'h00000000;
      end else begin
         hit_cnt_r <= cnt_next(hit_cnt_r, match_valid_r && match_hit_r, clr_hit);
         frm_cnt_r <= cnt_next(frm_cnt_r, match_valid_r, clr_frm);
      end
   end

   // ========================================================================
   // Outputs, all straight from flip-flops.
   assign AVS_WAITREQUEST = wait_r;
   assign AVS_READDATA = rdata_r;
   assign MATCH_VALID = match_valid_r;
   assign MATCH_HIT = match_hit_r;

endmodule

// >>> bench/aim_core_asserts.sv
// Concurrent checks on the ports of the access rule entry matcher.
`timescale 1ns/10ps
`include "aim_regs.vh"
module aim_core_asserts (
   // Clock and reset.
   input wire SYS_CLK,
   input wire RESET,
   // Register bus.
   input wire [7:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   input wire [31:0] AVS_READDATA,
   input wire AVS_WAITREQUEST,
   // Frame fields and result.
   input wire FRM_VALID,
   input wire [15:0] FRM_OPCODE,
   input wire [15:0] FRM_HRD,
   input wire [7:0] FRM_HLN,
   input wire [7:0] FRM_PLN,
   input wire [47:0] FRM_SOURCE_MAC,
   input wire [47:0] FRM_SHA,
   input wire MATCH_VALID,
   input wire MATCH_HIT
);
   // ==========
   // Shadow of the control word.
   reg [31:0] ctrl_r;
   wire [31:0] lane_m;
   wire [31:0] ctrl_nxt;
   wire op_arp;
   wire op_known;
   // Byte lanes merge as in the slave.
   assign lane_m = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}},
                    {8{AVS_BYTEENABLE[0]}}} & `AIM_CTRL_MASK;
   assign ctrl_nxt = (ctrl_r & ~lane_m) | (AVS_WRITEDATA & lane_m);
   assign op_arp = FRM_OPCODE == `AIM_OP_ARP_REQ || FRM_OPCODE == `AIM_OP_ARP_REP;
   assign op_known = FRM_OPCODE >= `AIM_OP_ARP_REQ && FRM_OPCODE <= `AIM_OP_RARP_REP;
   // Writes land where waitrequest is low.
   always @(posedge SYS_CLK) begin
      if (RESET) ctrl_r <= 32'h00000000;
      else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `AIM_OFS_CTRL) ctrl_r <= ctrl_nxt;
   end
   // ==========
   // Handshake and latency.
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);
   chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait low too long");
   chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request unanswered");
   chk_rdata_hold: assert property (AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
      else $error("read data moved");
   chk_match_lat: assert property (FRM_VALID |=> MATCH_VALID)
      else $error("result missing");
   chk_match_quiet: assert property (!FRM_VALID |=> !MATCH_VALID)
      else $error("stray result");
   chk_hit_valid: assert property (MATCH_HIT |-> MATCH_VALID)
      else $error("stray hit");
   // ==========
   // Vetoes.
   chk_dis_nohit: assert property (FRM_VALID && !ctrl_r[`AIM_CTRL_EN] |=> !MATCH_HIT)
      else $error("disabled hit");
   chk_opc_arp: assert property (FRM_VALID && ctrl_r[3:2] == `AIM_OPC_ARP && !op_arp |=> !MATCH_HIT)
      else $error("ARP class hit");
   chk_opc_other: assert property (FRM_VALID && ctrl_r[3:2] == `AIM_OPC_OTHER && op_known |=> !MATCH_HIT)
      else $error("other class hit");
   chk_rr_request: assert property (FRM_VALID && ctrl_r[5:4] == `AIM_RR_REQ && FRM_OPCODE != `AIM_OP_ARP_REQ
      && FRM_OPCODE != `AIM_OP_RARP_REQ |=> !MATCH_HIT) else $error("request hit");
   chk_len_one: assert property (FRM_VALID && ctrl_r[15:14] == 2'h3 && (FRM_HLN != `AIM_HLN_ETH
      || FRM_PLN != `AIM_PLN_IPV4) |=> !MATCH_HIT) else $error("length hit");
   chk_hrd_zero: assert property (FRM_VALID && ctrl_r[17:16] == 2'h2 && FRM_HRD == `AIM_HRD_ETH |=> !MATCH_HIT)
      else $error("space hit");
   chk_sha_one: assert property (FRM_VALID && ctrl_r[11:10] == 2'h3 && FRM_SHA != FRM_SOURCE_MAC |=> !MATCH_HIT)
      else $error("sender hw hit");
endmodule
bind aim_core aim_core_asserts i_chk (.SYS_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
   .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .FRM_VALID, .FRM_OPCODE, .FRM_HRD, .FRM_HLN, .FRM_PLN,
   .FRM_SOURCE_MAC, .FRM_SHA, .MATCH_VALID, .MATCH_HIT);

// >>> bench/aim_frame_src.sv
// Behavioural frame parser that offers parsed header fields to the matcher.
`timescale 1ns/10ps
module aim_frame_src (
   // Parsed frame fields.
   output wire frm_valid,
   output wire frm_is_arp,
   output wire [31:0] frm_dest_ip,
   output wire [47:0] frm_source_mac,
   output wire [15:0] frm_opcode,
   output wire [15:0] frm_hrd,
   output wire [7:0] frm_hln,
   output wire [7:0] frm_pln,
   output wire [47:0] frm_sha,
   output wire [47:0] frm_tha,
   output wire [31:0] frm_spa,
   output wire [31:0] frm_tpa
);
   // ==========
   // All fields in one word.
   logic vld_r = 1'b0;
   logic [288:0] fld_r = '0;
   assign frm_valid = vld_r;
   assign {frm_is_arp, frm_dest_ip, frm_source_mac, frm_opcode, frm_hrd, frm_hln, frm_pln, frm_sha, frm_tha,
           frm_spa, frm_tpa} = fld_r;
   // Offers one frame.
   task send(input logic arp, input logic [31:0] ip, input logic [47:0] mac, input logic [15:0] op,
             input logic [15:0] hrd, input logic [7:0] hln, input logic [47:0] sha, input logic [47:0] tha);
      vld_r <= 1'b1;
      fld_r <= {arp, ip, mac, op, hrd, hln, 8'h04, sha, tha, ip, ip};
   endtask
   // Fields flip between frames.
   task idle;
      vld_r <= 1'b0;
      fld_r <= ~fld_r;
   endtask
endmodule

// >>> bench/aim_core_tb_top.sv
// Self-checking bench for the access rule entry matcher.
`timescale 1ns/10ps
`include "aim_regs.vh"
module aim_core_tb_top;
   typedef struct packed {
      logic [19:0] ctrl;
      logic [3:0] op;
      logic [15:0] ip;
      logic [5:0] fl;
   } aim_row_t;
   localparam logic [47:0] MAC = 48'h0a0b0c0d0e0f;
   // ==========
   // Stimulus, wires and counters.
   logic SYS_CLK = 1'b0;
   logic RESET = 1'b1;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [3:0] AVS_BYTEENABLE = 4'h0;
   wire [31:0] AVS_READDATA;
   wire AVS_WAITREQUEST, FRM_VALID, FRM_IS_ARP, MATCH_VALID, MATCH_HIT;
   wire [31:0] FRM_DEST_IP, FRM_SPA, FRM_TPA;
   wire [47:0] FRM_SOURCE_MAC, FRM_SHA, FRM_THA;
   wire [15:0] FRM_OPCODE, FRM_HRD;
   wire [7:0] FRM_HLN, FRM_PLN;
   int error_cnt = 0;
   int checks = 0;
   logic [31:0] q;
   // Rows: ctrl, opcode, address low half, flags {arp, tha same, sha same, len ok, hrd 1, hit}.
   aim_row_t rows [44] = '{
      '{20'h00000, 4'h1, 16'h0101, 6'h2e}, '{20'h40000, 4'h1, 16'h0101, 6'h2f},
      '{20'h40001, 4'h1, 16'h0101, 6'h2f}, '{20'h40001, 4'h1, 16'h0102, 6'h2e},
      '{20'h40002, 4'h1, 16'h01aa, 6'h2f}, '{20'h40002, 4'h1, 16'h02aa, 6'h2e},
      '{20'h40000, 4'h7, 16'h0101, 6'h2f}, '{20'h40004, 4'h2, 16'h0101, 6'h2f},
      '{20'h40004, 4'h3, 16'h0101, 6'h2e}, '{20'h40008, 4'h4, 16'h0101, 6'h2f},
      '{20'h40008, 4'h1, 16'h0101, 6'h2e}, '{20'h4000c, 4'h5, 16'h0101, 6'h2f},
      '{20'h4000c, 4'h3, 16'h0101, 6'h2e}, '{20'h40010, 4'h3, 16'h0101, 6'h2f},
      '{20'h40010, 4'h2, 16'h0101, 6'h2e}, '{20'h40020, 4'h4, 16'h0101, 6'h2f},
      '{20'h40020, 4'h3, 16'h0101, 6'h2e}, '{20'h40040, 4'h1, 16'h0101, 6'h2f},
      '{20'h40040, 4'h1, 16'h0102, 6'h2e}, '{20'h40080, 4'h1, 16'h01aa, 6'h2f},
      '{20'h40080, 4'h1, 16'h02aa, 6'h2e}, '{20'h40100, 4'h1, 16'h0101, 6'h2f},
      '{20'h40100, 4'h1, 16'h0102, 6'h2e}, '{20'h40200, 4'h1, 16'h01aa, 6'h2f},
      '{20'h40200, 4'h1, 16'h02aa, 6'h2e}, '{20'h40c00, 4'h1, 16'h0101, 6'h2f},
      '{20'h40c00, 4'h1, 16'h0101, 6'h26}, '{20'h40800, 4'h1, 16'h0101, 6'h27},
      '{20'h40800, 4'h1, 16'h0101, 6'h2e}, '{20'h40400, 4'h1, 16'h0101, 6'h27},
      '{20'h43000, 4'h3, 16'h0101, 6'h3f}, '{20'h43000, 4'h3, 16'h0101, 6'h2e},
      '{20'h42000, 4'h3, 16'h0101, 6'h2f}, '{20'h42000, 4'h3, 16'h0101, 6'h3e},
      '{20'h4c000, 4'h1, 16'h0101, 6'h2f}, '{20'h4c000, 4'h1, 16'h0101, 6'h2a},
      '{20'h48000, 4'h1, 16'h0101, 6'h2e}, '{20'h48000, 4'h1, 16'h0101, 6'h2b},
      '{20'h60000, 4'h1, 16'h0101, 6'h2e}, '{20'h60000, 4'h1, 16'h0101, 6'h2d},
      '{20'h70000, 4'h1, 16'h0101, 6'h2f}, '{20'h70000, 4'h1, 16'h0101, 6'h2c},
      '{20'h4c014, 4'h1, 16'h0101, 6'h2f}, '{20'h4c014, 4'h1, 16'h0101, 6'h0e}};
   // ==========
   // Design and partner.
   aim_core i_dut (.SYS_CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
      .AVS_READDATA, .AVS_WAITREQUEST, .FRM_VALID, .FRM_IS_ARP, .FRM_DEST_IP, .FRM_SOURCE_MAC, .FRM_OPCODE,
      .FRM_HRD, .FRM_HLN, .FRM_PLN, .FRM_SHA, .FRM_THA, .FRM_SPA, .FRM_TPA, .MATCH_VALID, .MATCH_HIT);
   aim_frame_src i_src (.frm_valid(FRM_VALID), .frm_is_arp(FRM_IS_ARP), .frm_dest_ip(FRM_DEST_IP),
      .frm_source_mac(FRM_SOURCE_MAC), .frm_opcode(FRM_OPCODE), .frm_hrd(FRM_HRD), .frm_hln(FRM_HLN),
      .frm_pln(FRM_PLN), .frm_sha(FRM_SHA), .frm_tha(FRM_THA), .frm_spa(FRM_SPA), .frm_tpa(FRM_TPA));
   always #20 SYS_CLK = ~SYS_CLK;
   // ==========
   // Shared tasks.
   task cmp(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One access, held until waitrequest is low.
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int i;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge SYS_CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      cmp(i < 20, 32'h1, "waitrequest");
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task frm(input aim_row_t r);
      i_src.send(r.fl[5], {16'hc0a8, r.ip}, MAC, {12'h000, r.op}, r.fl[1] ? 16'h0001 : 16'h0006,
                 r.fl[2] ? 8'h06 : 8'h08, r.fl[3] ? MAC : ~MAC, r.fl[4] ? MAC : ~MAC);
   endtask
   // Result is checked in its one cycle.
   task run(input aim_row_t r, input logic exp);
      frm(r);
      @(posedge SYS_CLK);
      i_src.idle();
      @(posedge SYS_CLK);
      cmp(MATCH_VALID, 32'h1, "match_valid");
      cmp(MATCH_HIT, exp, "match_hit");
   endtask
   task give_verdict;
      if (error_cnt == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========
   // Main sequence.
   initial begin
      int k;
      repeat (5) @(posedge SYS_CLK);
      cmp(AVS_WAITREQUEST, 32'h1, "wait_in_reset");
      cmp(MATCH_VALID, 32'h0, "match_in_reset");
      RESET <= 1'b0;
      @(posedge SYS_CLK);
      bus(1'b0, `AIM_OFS_CTRL, 32'h0, 4'hf);
      cmp(q, `AIM_RST_CTRL, "ctrl_reset");
      for (k = 0; k < 6; k++) bus(1'b1, 8'h04 + 8'(4 * k), k[0] ? 32'hffffff00 : 32'hc0a80101, 4'hf);
      bus(1'b0, `AIM_OFS_DIP_MASK, 32'h0, 4'hf);
      cmp(q, 32'hffffff00, "dip_mask");
      foreach (rows[n]) begin
         bus(1'b1, `AIM_OFS_CTRL, {12'h000, rows[n].ctrl}, 4'hf);
         run(rows[n], rows[n].fl[0]);
      end
      // Back-to-back frames.
      bus(1'b1, `AIM_OFS_CTRL, 32'h00040001, 4'hf);
      frm(rows[2]);
      @(posedge SYS_CLK);
      frm(rows[3]);
      @(posedge SYS_CLK);
      cmp(MATCH_HIT, 32'h1, "first_hit");
      i_src.idle();
      @(posedge SYS_CLK);
      cmp(MATCH_VALID, 32'h1, "second_valid");
      cmp(MATCH_HIT, 32'h0, "second_hit");
      // Lane 2 holds the enable bit.
      bus(1'b1, `AIM_OFS_CTRL, 32'h0, 4'hb);
      bus(1'b0, `AIM_OFS_CTRL, 32'h0, 4'hf);
      cmp(q, 32'h00040000, "ctrl_lanes");
      run(rows[1], 1'b1);
      bus(1'b1, `AIM_OFS_CTRL, 32'h0, 4'h4);
      run(rows[1], 1'b0);
      // Unmapped address.
      bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
      bus(1'b0, 8'h40, 32'h0, 4'hf);
      cmp(q, 32'h0, "unmapped");
      // Mid-run reset.
      RESET <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RESET <= 1'b0;
      @(posedge SYS_CLK);
      bus(1'b0, `AIM_OFS_DIP_MASK, 32'h0, 4'hf);
      cmp(q, `AIM_RST_WORD, "mask_after_reset");
      give_verdict();
   end
   // Watchdog.
   initial begin
      repeat (5000) @(posedge SYS_CLK);
      error_cnt++;
      give_verdict();
   end
endmodule
